// [test/twb_target_model.sv]
/*
 * Behavioural target device on the two-wire bus.
 * Assumes pulled-up lines; it only ever pulls the data line low.
 */
`timescale 1ns/1ps
module twb_target_model
#(
    parameter logic [6:0] ADDR = 7'h51,
    parameter logic [7:0] RDATA = 8'ha5
)
(
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_pull_out,
    output logic [7:0] got_out
);
    int bits = 0;
    logic first = 1'b0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic [7:0] sh = 8'h00;
    initial sda_pull_out = 1'b0;
    initial got_out = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // Start or stop restarts framing and deselects
    always @(sda_in)
        if (scl_in === 1'b1)
        begin
            bits = 0;
            first = !sda_in;
            sel = 1'b0;
            sda_pull_out = 1'b0;
        end
    // Sample data; a master no-ack ends our read
    always @(posedge scl_in)
    begin
        if (bits < 8)
            sh = {sh[6:0], sda_in};
        else if (!first && rd && sda_in)
            sel = 1'b0;
        bits++;
    end
    // Change data only while the clock is low
    always @(negedge scl_in)
    begin
        if (bits == 8)
        begin
            if (first)
            begin
                sel = sh[7:1] == ADDR;
                rd = sh[0];
            end
            else if (sel && !rd)
                got_out = sh;
            sda_pull_out = sel && (first || !rd);
        end
        else if (bits == 9)
        begin
            bits = 0;
            first = 1'b0;
            sda_pull_out = sel && rd && !RDATA[7];
        end
        else if (sel && rd && !first)
            sda_pull_out = !RDATA[7 - bits];
    end
endmodule

// [test/two_wire_bus_controller_bench.sv]
/*
 * Self-checking bench for the two-wire bus controller as a master.
 * Assumes a pulled-up bus on the selected port and one target model.
 */
`timescale 1ns/1ps
module two_wire_bus_controller_bench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [0:0] reg_addr_in = 1'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [7:0] config_in = 8'h00;
    logic [1:0] p1_out, p1_oe_out, p2_out, p2_oe_out;
    logic p1_od_force_out, p2_od_force_out, irq_out;
    logic on2 = 1'b0;
    logic ext_pull = 1'b0;
    logic tgt_pull;
    logic [7:0] tgt_got;
    int fail_count = 0;
    int num_checks = 0;
    int stops = 0;
    // Wired-and bus on whichever port carries it
    wire [1:0] oe_w = on2 ? p2_oe_out : p1_oe_out;
    wire scl_w = !oe_w[0];
    wire sda_w = !(oe_w[1] || tgt_pull || ext_pull);
    wire [1:0] p1_pin_in = on2 ? 2'h3 : {sda_w, scl_w};
    wire [1:0] p2_pin_in = on2 ? {sda_w, scl_w} : 2'h3;
    ////////////////////////////////////////////////////////////////////////
    two_wire_bus_controller #(.QUARTER(3)) dut_u (.clk_in(clk_in),
        .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .config_in(config_in), .p1_pin_in(p1_pin_in),
        .p2_pin_in(p2_pin_in), .p1_out(p1_out), .p1_oe_out(p1_oe_out),
        .p2_out(p2_out), .p2_oe_out(p2_oe_out),
        .p1_od_force_out(p1_od_force_out),
        .p2_od_force_out(p2_od_force_out), .irq_out(irq_out));
    twb_target_model tgt_u (.scl_in(scl_w), .sda_in(sda_w),
        .sda_pull_out(tgt_pull), .got_out(tgt_got));
    // Clock of 4 ns; stop conditions counted on the wire
    always #2 clk_in = ~clk_in;
    always @(posedge sda_w)
        if (scl_w === 1'b1)
            stops++;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobe for one cycle, then idle one cycle so strobes never collide
    task automatic wr(input logic [0:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rdchk(input logic [0:0] a, logic [7:0] m, logic [7:0] e);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk("rdata", e, reg_rdata_out & m);
        @(posedge clk_in);
    endtask
    // Bounded wait: a byte is far shorter than this
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_out !== 1'b1 && n < 3000)
        begin
            @(posedge clk_in);
            n++;
        end
        chk("irq", 8'h01, {7'h0, irq_out});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the expected run
    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end
    initial
    begin
        int s;
        cyc(16);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rdchk(1'h1, 8'hff, 8'h00);
        chk("irq", 8'h00, {7'h0, irq_out});
        wr(1'h1, 8'h01);
        cyc(3);
        chk("od", 8'h01, {p2_od_force_out, p1_od_force_out});
        config_in <= 8'h80;
        cyc(3);
        chk("od", 8'h02, {p2_od_force_out, p1_od_force_out});
        config_in <= 8'h02;
        cyc(3);
        chk("od", 8'h02, {p2_od_force_out, p1_od_force_out});
        wr(1'h1, 8'h00);
        cyc(3);
        chk("od", 8'h00, {p2_od_force_out, p1_od_force_out});
        config_in <= 8'h00;
        $display("test pins done");
        // Master write: address, one data byte, stop
        wr(1'h0, {7'h51, 1'b0});
        wr(1'h1, 8'hc1);
        rdchk(1'h1, 8'h40, 8'h40);
        wr(1'h1, 8'h00);
        wait_irq();
        rdchk(1'h1, 8'hd0, 8'h90);
        cyc(30);
        chk("scl_hold", 8'h01, {7'h0, p1_oe_out[0]});
        wr(1'h0, 8'h3c);
        wr(1'h1, 8'he1);
        wait_irq();
        chk("target", 8'h3c, tgt_got);
        s = stops;
        wr(1'h1, 8'h01);
        cyc(100);
        chk("stop", 8'h01, 8'(stops - s));
        chk("oe", 8'h00, {6'h0, p1_oe_out});
        $display("test write done");
        // Unanswered address on the second port
        config_in <= 8'h80;
        on2 <= 1'b1;
        wr(1'h0, {7'h12, 1'b0});
        wr(1'h1, 8'hc1);
        wait_irq();
        rdchk(1'h1, 8'h90, 8'h80);
        wr(1'h1, 8'h01);
        cyc(100);
        config_in <= 8'h00;
        on2 <= 1'b0;
        $display("test noack done");
        // Repeated start into a read, last byte not acknowledged
        wr(1'h0, {7'h51, 1'b0});
        wr(1'h1, 8'hc1);
        wait_irq();
        wr(1'h0, {7'h51, 1'b1});
        wr(1'h1, 8'hc5);
        wait_irq();
        rdchk(1'h1, 8'h84, 8'h80);
        wr(1'h1, 8'hc1);
        wait_irq();
        rdchk(1'h0, 8'hff, 8'ha5);
        rdchk(1'h1, 8'h82, 8'h80);
        wr(1'h1, 8'h01);
        cyc(100);
        $display("test restart read done");
        // Another party holds data low during our address
        wr(1'h0, 8'hfe);
        wr(1'h1, 8'hc1);
        for (int n = 0; n < 300 && p1_oe_out[0] !== 1'b1; n++)
            @(posedge clk_in);
        ext_pull <= 1'b1;
        cyc(40);
        // Other party lets go with clock high: its stop ends the transfer
        ext_pull <= 1'b0;
        wait_irq();
        rdchk(1'h1, 8'h8c, 8'h0c);
        wr(1'h1, 8'h00);
        cyc(50);
        $display("test arbitration done");
        final_report();
    end
endmodule

// [verilog/twb_pin_mux.sv]
/*
 * Selects the port that carries the bus and synchronises the two lines.
 * Assumes port inputs are asynchronous pins.
 */
`timescale 1ns/1ps
module twb_pin_mux
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic use_p2_in,
    input wire logic [1:0] p1_pin_in,
    input wire logic [1:0] p2_pin_in,
    twb_pins_if.pins bus
);
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] sel;

    // Raw selection; only the first stage reads it
    assign sel = use_p2_in ? p2_pin_in : p1_pin_in;

    // Two flip-flops before any logic looks at the lines
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
        end
        else
        begin
            s1_q <= sel;
            s2_q <= s1_q;
        end
    end

    assign bus.scl_seen = s2_q[twb_pkg::PIN_SCL];
    assign bus.sda_seen = s2_q[twb_pkg::PIN_SDA];
endmodule

// [verilog/twb_pins_if.sv]
/*
 * Interface carrying the synchronised bus pins between the controller
 * and its pin steering. Assumes both ends share clk_in.
 */
`timescale 1ns/1ps
interface twb_pins_if;
    logic scl_pull;
    logic sda_pull;
    logic scl_seen;
    logic sda_seen;
    modport core (output scl_pull, output sda_pull,
        input scl_seen, input sda_seen);
    modport pins (input scl_pull, input sda_pull,
        output scl_seen, output sda_seen);
endinterface

// [verilog/twb_pkg.sv]
/*
 * Constants shared by the two-wire bus controller and its pin mux.
 * Assumes a single 250 MHz core clock and a plain register port.
 */
// Functional notes
// - Interrupt after each byte, slave-receive stop, and arbitration loss.
// - Hold the bus clock low while firmware services an interrupt.
// - Clock on port bit 0, data on port bit 1.
// - Enable bit forces the two bus pins to open-drain.
// - Enable clear returns the pins to general-purpose use.
// - Stop flag only in slave receive, and not after our no-ack.
// - Arbitration loss clears master, sets lost flag, interrupts.
// - Repeat start needs address first; hardware clears the restart bit.
// - Address flag set on first slave byte or lost arbitration.
// - Receive: acknowledge bit 1 pulls data low at acknowledge time.
// - Master transmit: acknowledge bit shows whether the receiver acknowledged.
// - Transmit bit picks direction, ignored for first master byte.
// - Busy bit reads 1 during a transfer; writing 1 continues.
// - Control writes are ignored while busy.
// - No busy again after an interrupt until continue is written.
// - Setting master issues start and sends the data register.
// - Each later master byte waits for continue.
// - Master bit written 1 to 0 produces a stop.
// - Master drives clock, arbitrates and synchronises clocks.
// - Interrupt held off while an external master addresses us.
// - Data register has separate read and write storage.
// - Config bit 1 or bit 7 selects the second port.
package twb_pkg;
    localparam logic [0:0] ADDR_DATA = 1'h0;
    localparam logic [0:0] ADDR_CTRL = 1'h1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int B_ENABLE = 0;
    localparam int B_STOP = 1;
    localparam int B_ARB = 2;
    localparam int B_ADDR = 3;
    localparam int B_ACK = 4;
    localparam int B_XMIT = 5;
    localparam int B_BUSY = 6;
    localparam int B_MASTER = 7;
    localparam int CFG_WIDTH1 = 1;
    localparam int CFG_POS = 7;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int CLK_MHZ = 250;
    localparam int SCL_KHZ = 100;
    localparam int QUARTER = CLK_MHZ * 1000 / (SCL_KHZ * 4);
endpackage

// [verilog/two_wire_bus_controller.sv]
/*
 * Byte-level two-wire bus controller: master, slave, multi-master.
 * Assumes open-drain pads outside; output enable high means pull low.
 */
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module two_wire_bus_controller
#(
    parameter int QUARTER = twb_pkg::QUARTER,
    parameter logic [6:0] OWN_ADDR = 7'h2a
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [0:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [7:0] config_in,
    input wire logic [1:0] p1_pin_in,
    input wire logic [1:0] p2_pin_in,
    output logic [1:0] p1_out,
    output logic [1:0] p1_oe_out,
    output logic [1:0] p2_out,
    output logic [1:0] p2_oe_out,
    output logic p1_od_force_out,
    output logic p2_od_force_out,
    output logic irq_out
);
    typedef enum {
        S_IDLE, S_START, S_BIT, S_ACK, S_WAIT, S_STOP, S_RESTART
    } state_e;

    twb_pins_if bus ();
    logic use_p2;
    logic [7:0] ctrl_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] sh_q;
    logic [2:0] bit_q;
    logic [1:0] ph_q;
    logic [15:0] div_q;
    logic tick;
    state_e st_q;
    logic scl_pull_q;
    logic sda_pull_q;
    logic scl_d1_q;
    logic sda_d1_q;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic slave_q;
    logic first_q;
    logic addressed_q;
    logic rx_mode_q;
    logic nack_end_q;
    logic held_irq_q;
    logic irq_q;
    logic ctrl_wr;
    logic data_wr;
    logic busy;
    logic ena;
    logic go;

    ////////////////////////////////////////////////////////////////
    // Pin steering and selection
    assign use_p2 = config_in[twb_pkg::CFG_WIDTH1]
        | config_in[twb_pkg::CFG_POS];
    assign ena = ctrl_q[twb_pkg::B_ENABLE];

    twb_pin_mux u_mux
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .use_p2_in(use_p2),
        .p1_pin_in(p1_pin_in),
        .p2_pin_in(p2_pin_in),
        .bus(bus.pins)
    );

    assign bus.scl_pull = scl_pull_q;
    assign bus.sda_pull = sda_pull_q;

    // Open-drain: data out is always 0, enables pull low
    assign p1_out = 2'h0;
    assign p2_out = 2'h0;
    assign p1_oe_out = (ena && !use_p2)
        ? {bus.sda_pull, bus.scl_pull} : 2'h0;
    assign p2_oe_out = (ena && use_p2)
        ? {bus.sda_pull, bus.scl_pull} : 2'h0;
    // Cleared enable hands pins back to general-purpose logic
    assign p1_od_force_out = ena && !use_p2;
    assign p2_od_force_out = ena && use_p2;

    ////////////////////////////////////////////////////////////////
    // Bus condition detection on synchronised lines
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end
        else
        begin
            scl_d1_q <= bus.scl_seen;
            sda_d1_q <= bus.sda_seen;
        end
    end

    assign scl_rise = bus.scl_seen && !scl_d1_q;
    assign scl_fall = !bus.scl_seen && scl_d1_q;
    assign start_seen = bus.scl_seen && scl_d1_q
        && sda_d1_q && !bus.sda_seen;
    assign stop_seen = bus.scl_seen && scl_d1_q
        && !sda_d1_q && bus.sda_seen;

    ////////////////////////////////////////////////////////////////
    // Quarter-bit divider; halts while another party stretches clock
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            div_q <= 16'h0000;
        else if (tick || st_q == S_IDLE || st_q == S_WAIT)
            div_q <= 16'h0000;
        else if (!(scl_pull_q == 1'b0 && !bus.scl_seen))
            div_q <= div_q + 16'h0001; // clock sync wait
    end
    assign tick = (div_q == 16'(QUARTER - 1));

    ////////////////////////////////////////////////////////////////
    // Register port decode
    assign busy = ctrl_q[twb_pkg::B_BUSY];
    assign data_wr = reg_wr_in && reg_addr_in == twb_pkg::ADDR_DATA;
    assign ctrl_wr = reg_wr_in && reg_addr_in == twb_pkg::ADDR_CTRL
        && !busy;
    assign go = ctrl_wr && reg_wdata_in[twb_pkg::B_BUSY];

    // Write-side data store, separate from received byte
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            tx_q <= 8'h00;
        else if (data_wr)
            tx_q <= reg_wdata_in;
    end

    // Read data stands for one cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
            reg_rdata_out <= (reg_addr_in == twb_pkg::ADDR_DATA)
                ? rx_q : ctrl_q;
        else
            reg_rdata_out <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////
    // Byte engine: control register, shifter, interrupt
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl_q <= twb_pkg::CTRL_RESET;
            st_q <= S_IDLE;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            bit_q <= 3'h0;
            ph_q <= 2'h0;
            scl_pull_q <= 1'b0;
            sda_pull_q <= 1'b0;
            slave_q <= 1'b0;
            first_q <= 1'b0;
            addressed_q <= 1'b0;
            rx_mode_q <= 1'b0;
            nack_end_q <= 1'b0;
            held_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                // Control write: take enable, ack, transmit, master and bit 2; clear stop, clear address on continue
                ctrl_q[twb_pkg::B_ENABLE] <= reg_wdata_in[0];
                ctrl_q[twb_pkg::B_ACK] <= reg_wdata_in[4];
                ctrl_q[twb_pkg::B_XMIT] <= reg_wdata_in[5];
                ctrl_q[twb_pkg::B_MASTER] <= reg_wdata_in[7];
                ctrl_q[twb_pkg::B_ARB] <= reg_wdata_in[2];
                ctrl_q[twb_pkg::B_STOP] <= 1'b0;
                ctrl_q[twb_pkg::B_BUSY] <= reg_wdata_in[6]
                    || (reg_wdata_in[7] && !ctrl_q[7]);
                if (reg_wdata_in[6])
                    ctrl_q[twb_pkg::B_ADDR] <= 1'b0;
                irq_q <= 1'b0;
                if (reg_wdata_in[6] && !reg_wdata_in[4]
                    && !reg_wdata_in[5] && slave_q)
                    nack_end_q <= 1'b1;
            end
            // Enable and master may arrive in one write, so look ahead
            if (!ena && !(ctrl_wr && reg_wdata_in[twb_pkg::B_ENABLE]))
                st_q <= S_IDLE;
            else
            case (st_q)
            S_IDLE:
            begin
                scl_pull_q <= 1'b0;
                sda_pull_q <= 1'b0;
                if (ctrl_wr && reg_wdata_in[7] && !ctrl_q[7])
                begin
                    sh_q <= tx_q;
                    rx_mode_q <= 1'b0;
                    slave_q <= 1'b0;
                    st_q <= S_START;
                    ph_q <= 2'h0;
                end
                else if (start_seen)
                begin
                    slave_q <= 1'b1;
                    first_q <= 1'b1;
                    rx_mode_q <= 1'b1;
                    bit_q <= 3'h7;
                    st_q <= S_BIT;
                end
            end
            S_START:
                if (tick)
                begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h1)
                        sda_pull_q <= 1'b1; // start: data falls, clock high
                    if (ph_q == 2'h3)
                    begin
                        scl_pull_q <= 1'b1;
                        bit_q <= 3'h7;
                        st_q <= S_BIT;
                    end
                end
            S_RESTART:
                if (tick)
                begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0)
                        sda_pull_q <= 1'b0;
                    if (ph_q == 2'h1)
                        scl_pull_q <= 1'b0;
                    if (ph_q == 2'h2)
                    begin
                        sda_pull_q <= 1'b1;
                        ctrl_q[twb_pkg::B_ARB] <= 1'b0;
                    end
                    if (ph_q == 2'h3)
                    begin
                        scl_pull_q <= 1'b1;
                        bit_q <= 3'h7;
                        st_q <= S_BIT;
                    end
                end
            S_BIT, S_ACK:
            begin
                if (stop_seen && slave_q)
                begin
                    // Stop from the outside master ends the slave transfer
                    if (rx_mode_q && !nack_end_q && !first_q)
                    begin
                        ctrl_q[twb_pkg::B_STOP] <= 1'b1;
                        irq_q <= 1'b1;
                    end
                    if (held_irq_q)
                        irq_q <= 1'b1;
                    held_irq_q <= 1'b0;
                    slave_q <= 1'b0;
                    nack_end_q <= 1'b0;
                    ctrl_q[twb_pkg::B_BUSY] <= 1'b0;
                    st_q <= S_IDLE;
                end
                else if (slave_q)
                begin
                    // Slave: drive on falling clock, sample on rising
                    if (scl_fall)
                        sda_pull_q <= (st_q == S_ACK)
                            ? (rx_mode_q && (first_q
                                || ctrl_q[twb_pkg::B_ACK]))
                            : (!rx_mode_q && !sh_q[bit_q]);
                    if (scl_rise)
                    begin
                        if (st_q == S_BIT)
                        begin
                            sh_q[bit_q] <= bus.sda_seen;
                            if (bit_q == 3'h0)
                                st_q <= S_ACK;
                            bit_q <= bit_q - 3'h1;
                        end
                        else
                            st_q <= S_WAIT;
                    end
                end
                else if (tick)
                begin
                    // Master: four quarters per bit
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0)
                        sda_pull_q <= (st_q == S_ACK)
                            ? (rx_mode_q && ctrl_q[twb_pkg::B_ACK])
                            : (!rx_mode_q && !sh_q[bit_q]);
                    if (ph_q == 2'h1)
                        scl_pull_q <= 1'b0;
                    if (ph_q == 2'h2)
                    begin
                        if (st_q == S_BIT && !rx_mode_q && !sda_pull_q
                            && !bus.sda_seen)
                        begin
                            // Someone else drove low: arbitration lost
                            ctrl_q[twb_pkg::B_MASTER] <= 1'b0;
                            ctrl_q[twb_pkg::B_ARB] <= 1'b1;
                            ctrl_q[twb_pkg::B_ADDR] <= 1'b1;
                            ctrl_q[twb_pkg::B_BUSY] <= 1'b0;
                            sda_pull_q <= 1'b0;
                            scl_pull_q <= 1'b0;
                            slave_q <= 1'b1;
                            rx_mode_q <= 1'b1;
                            first_q <= 1'b1;
                            held_irq_q <= 1'b1;
                            st_q <= S_BIT;
                        end
                        else if (st_q == S_BIT)
                            sh_q[bit_q] <= bus.sda_seen;
                        else if (!rx_mode_q)
                            ctrl_q[twb_pkg::B_ACK] <= !bus.sda_seen;
                    end
                    if (ph_q == 2'h3)
                    begin
                        scl_pull_q <= 1'b1;
                        if (st_q == S_ACK)
                            st_q <= S_WAIT;
                        else
                        begin
                            if (bit_q == 3'h0)
                                st_q <= S_ACK;
                            bit_q <= bit_q - 3'h1;
                        end
                    end
                end
            end
            S_WAIT:
            begin
                // Byte done: clock held low until firmware answers
                if (slave_q)
                    scl_pull_q <= 1'b1;
                if ((ctrl_q[twb_pkg::B_BUSY] || first_q) && !irq_q && !go)
                begin
                    rx_q <= sh_q;
                    ctrl_q[twb_pkg::B_BUSY] <= 1'b0;
                    if (slave_q && first_q)
                    begin
                        ctrl_q[twb_pkg::B_ADDR] <= 1'b1;
                        // Not our address: drop out, raise any held arbitration-loss interrupt
                        if (sh_q[7:1] != OWN_ADDR)
                        begin
                            irq_q <= held_irq_q;
                            held_irq_q <= 1'b0;
                            slave_q <= 1'b0;
                            scl_pull_q <= 1'b0;
                            st_q <= S_IDLE;
                        end
                        else
                        begin
                            rx_mode_q <= !sh_q[0];
                            if (held_irq_q)
                                irq_q <= 1'b0;
                            else
                                irq_q <= 1'b1;
                        end
                    end
                    else if (!held_irq_q)
                        irq_q <= 1'b1;
                    first_q <= 1'b0;
                end
                else if (go)
                begin
                    // Firmware answered: next byte, restart or stop
                    sh_q <= tx_q;
                    bit_q <= 3'h7;
                    ph_q <= 2'h0;
                    if (!slave_q && reg_wdata_in[7]
                        && reg_wdata_in[2])
                    begin
                        rx_mode_q <= 1'b0;
                        st_q <= S_RESTART;
                    end
                    else if (!slave_q && !reg_wdata_in[7])
                        st_q <= S_STOP;
                    else
                    begin
                        rx_mode_q <= !reg_wdata_in[5];
                        scl_pull_q <= slave_q ? 1'b0 : 1'b1;
                        st_q <= S_BIT;
                    end
                end
                else if (ctrl_wr && !reg_wdata_in[7] && ctrl_q[7])
                begin
                    ph_q <= 2'h0;
                    st_q <= S_STOP;
                end
            end
            S_STOP:
                if (tick)
                begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0)
                        sda_pull_q <= 1'b1;
                    if (ph_q == 2'h1)
                        scl_pull_q <= 1'b0;
                    if (ph_q == 2'h3)
                    begin
                        sda_pull_q <= 1'b0; // stop: data rises, clock high
                        ctrl_q[twb_pkg::B_BUSY] <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
            default:
                st_q <= S_IDLE;
            endcase
        end
    end

    assign irq_out = irq_q;

    ////////////////////////////////////////////////////////////////
    // Checks
    property p_busy_lock;
        @(posedge clk_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == twb_pkg::ADDR_CTRL && busy)
        |=> ctrl_q[twb_pkg::B_ENABLE] == $past(ctrl_q[twb_pkg::B_ENABLE]);
    endproperty
    a_busy_lock: assert property (p_busy_lock)
        else $error("control write taken while busy");

    property p_arb;
        @(posedge clk_in) disable iff (rst_in)
        $rose(ctrl_q[twb_pkg::B_ARB]) && !$past(ctrl_wr)
        |-> !ctrl_q[twb_pkg::B_MASTER];
    endproperty
    a_arb: assert property (p_arb)
        else $error("arbitration lost with master still set");

    property p_release;
        @(posedge clk_in) disable iff (rst_in)
        !ena |-> p1_oe_out == 2'h0 && p2_oe_out == 2'h0;
    endproperty
    a_release: assert property (p_release)
        else $error("pins driven while disabled");

    // Master waiting on firmware must keep the clock pulled low
    property p_stretch;
        @(posedge clk_in) disable iff (rst_in)
        st_q == S_WAIT && !slave_q |-> scl_pull_q;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("master clock not held while waiting");

    property p_restart_clear;
        @(posedge clk_in) disable iff (rst_in)
        st_q == S_RESTART && tick && ph_q == 2'h2
        |=> !ctrl_q[twb_pkg::B_ARB];
    endproperty
    a_restart_clear: assert property (p_restart_clear)
        else $error("restart bit left set after restart");

    property p_irq_idle;
        @(posedge clk_in) disable iff (rst_in)
        $rose(irq_q) |-> !busy;
    endproperty
    a_irq_idle: assert property (p_irq_idle)
        else $error("interrupt raised while still busy");
endmodule
